/* core/bts_pkg.sv */
// Purpose: Shared constants and state types of the transfer scheme
// Assumes: 50 MHz system clock
// Notes:   Times are kept in ms; cycle counts derive from them
package bts_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned XFER_DELAY_MS = 100;
  localparam int unsigned UV_DELAY_MS   = 500;
  localparam int unsigned XFER_DELAY_CYC = XFER_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned UV_DELAY_CYC   = UV_DELAY_MS * (CLK_HZ / 1000);

  localparam int unsigned SYNC_W    = 22;
  localparam int unsigned LOG_AW    = 5;
  localparam int unsigned LOG_DEPTH = 32;
  localparam int unsigned SNAP_W    = 27;

  // Bit positions inside one incomer byte of the sampled input vector
  localparam int unsigned IN_CONN    = 0;
  localparam int unsigned IN_RCLOSE  = 1;
  localparam int unsigned IN_ROPEN   = 2;
  localparam int unsigned IN_BLOCK   = 3;
  localparam int unsigned IN_LOCK    = 4;
  localparam int unsigned IN_SRCTRIP = 5;
  localparam int unsigned IN_SRCOK   = 6;
  localparam int unsigned IN_BRKCL   = 7;
  // Bus-tie inputs follow the two incomer bytes
  localparam int unsigned T_CONN     = 16;
  localparam int unsigned T_RCLOSE   = 17;
  localparam int unsigned T_ROPEN    = 18;
  localparam int unsigned T_BRKCL    = 19;
  localparam int unsigned T_BUSDEAD  = 20;
  localparam int unsigned T_LINEDEAD = 21;

  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CMD      = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_LOG_CNT  = 8'h0c;
  localparam logic [7:0] REG_LOG_IDX  = 8'h10;
  localparam logic [7:0] REG_LOG_DATA = 8'h14;
  localparam logic [7:0] REG_INPUTS   = 8'h18;

  typedef logic [6:0] bts_rly_t;

  typedef struct packed {
    logic [2:0]              cmd;
    logic [1:0]              cls_pend;
    logic [1:0]              inc_req;
    logic [1:0]              tie_req;
    logic [1:0][31:0]        uv_cnt;
    logic [1:0][31:0]        dly_cnt;
    logic [1:0]              nr;
    logic [SNAP_W-1:0]       snap;
    logic [LOG_AW:0]         wptr;
    logic [4:0]              seq;
    logic                    auto_en;
    logic [LOG_AW-1:0]       log_idx;
    logic [2:0]              sw_close;
    logic [2:0]              sw_open;
    logic [31:0]             prdata;
    logic                    pslverr;
    bts_rly_t                rly0;
    bts_rly_t                rly1;
    bts_rly_t                rlyt;
    logic                    log_wr;
    logic [31:0]             log_wdata;
    logic [LOG_AW-1:0]       log_waddr;
  } bts_state_t;

  localparam logic AUTO_EN_RST = 1'b1;
  // Relay 3 carries the not-ready flag, so both leave reset flagged
  localparam logic [1:0] NR_RST      = 2'h3;
  localparam bts_rly_t   RLY_INC_RST = 7'h0d;
  localparam bts_rly_t   RLY_TIE_RST = 7'h01;

  function automatic int unsigned bts_bit(input int unsigned unit, input int unsigned idx);
    return unit * 8 + idx;
  endfunction
endpackage

/* core/bts_if.sv */
// Purpose: Carrier between the scheme core, its sampler and its log
// Assumes: One clock domain
// Notes:   Plain signals, no clocking
interface bts_if;
  import bts_pkg::*;
  logic [SYNC_W-1:0] lvl;
  logic [SYNC_W-1:0] rise;
  logic              wr;
  logic [LOG_AW-1:0] waddr;
  logic [LOG_AW-1:0] raddr;
  logic [31:0]       wdata;
  logic [31:0]       rdata;
  modport syncer (output lvl, rise);
  modport logmem (input wr, waddr, wdata, raddr, output rdata);
  modport core   (input lvl, rise, rdata, output wr, waddr, wdata, raddr);
endinterface

/* core/bts_sync.sv */
// Purpose: Two-stage sampler of the scheme inputs with rising-edge detect
// Assumes: Inputs are asynchronous contacts
// Notes:   Edge detect looks only at the second stage
module bts_sync (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // Raw pins and sampled view
  input  wire logic [bts_pkg::SYNC_W-1:0] raw_i,
  bts_if.syncer                      port
);
  import bts_pkg::*;
  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] lvl;
    logic [SYNC_W-1:0] prev;
  } bts_sync_t;
  bts_sync_t s, next_s;

  always_comb begin
    next_s      = s;
    next_s.meta = raw_i;
    next_s.lvl  = s.meta;
    next_s.prev = s.lvl;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign port.lvl  = s.lvl;
  // One-cycle pulse per rising edge, so a held pulse counts once
  assign port.rise = s.lvl & ~s.prev;
endmodule // bts_sync

/* core/bts_evlog.sv */
// Purpose: Event log memory with registered read data
// Assumes: Writer keeps its own pointer
// Notes:   Array has no reset; only the read register does
module bts_evlog (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Log port
  bts_if.logmem     port
);
  import bts_pkg::*;
  logic [31:0] mem [LOG_DEPTH];
  logic [31:0] rdata;

  always_ff @(posedge clk_i) begin
    if (port.wr) begin
      mem[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata <= 32'h0;
    end else begin
      rdata <= mem[port.raddr];
    end
  end

  assign port.rdata = rdata;
endmodule // bts_evlog

/* core/bts_scheme.sv */
// Purpose: Two-incomer, one-tie automatic transfer interlock with APB access
// Assumes: Breaker status and voltage status arrive as contacts
// Notes:   Relay outputs lag the sampled inputs by one cycle, those fed from command or request state by two
module bts_scheme #(
  parameter int unsigned XFER_CYC = bts_pkg::XFER_DELAY_CYC,
  parameter int unsigned UV_CYC   = bts_pkg::UV_DELAY_CYC
) (
  // Clock and reset
  input  wire logic             CLK_SYS_I,
  input  wire logic             RST_N_I,
  // APB slave
  input  wire logic             PSEL_I,
  input  wire logic             PENABLE_I,
  input  wire logic             PWRITE_I,
  input  wire logic [7:0]       PADDR_I,
  input  wire logic [31:0]      PWDATA_I,
  output logic [31:0]           PRDATA_O,
  output logic                  PREADY_O,
  output logic                  PSLVERR_O,
  // Incomer inputs, bit 0 incomer 1, bit 1 incomer 2
  input  wire logic [1:0]       INC_CONN_I,
  input  wire logic [1:0]       INC_RCLOSE_I,
  input  wire logic [1:0]       INC_ROPEN_I,
  input  wire logic [1:0]       INC_BLOCK_I,
  input  wire logic [1:0]       INC_LOCKOUT_I,
  input  wire logic [1:0]       INC_SRCTRIP_I,
  input  wire logic [1:0]       INC_SRC_OK_I,
  input  wire logic [1:0]       INC_BRK_CLOSED_I,
  // Bus-tie inputs
  input  wire logic             TIE_CONN_I,
  input  wire logic             TIE_RCLOSE_I,
  input  wire logic             TIE_ROPEN_I,
  input  wire logic             TIE_BRK_CLOSED_I,
  input  wire logic             TIE_BUS_DEAD_I,
  input  wire logic             TIE_LINE_DEAD_I,
  // Output relays, bit k is relay k+1
  output bts_pkg::bts_rly_t     INC0_RELAY_O,
  output bts_pkg::bts_rly_t     INC1_RELAY_O,
  output bts_pkg::bts_rly_t     TIE_RELAY_O,
  output logic [1:0]            INC_NOT_READY_O
);
  import bts_pkg::*;

  bts_if u_if ();
  bts_state_t s, next_s;

  logic [SYNC_W-1:0] raw;
  logic [1:0]        conn, block, lock, srctrip, src_ok, brk;
  logic [1:0]        rclose_p, ropen_p, lock_p, srctrip_p;
  logic [1:0]        hold, uv_trip, trip, close_cmd;
  logic              common_nr, tie_close, tie_open;
  logic [SNAP_W-1:0] snap_now;
  logic              setup, access;

  assign raw = {TIE_LINE_DEAD_I, TIE_BUS_DEAD_I, TIE_BRK_CLOSED_I, TIE_ROPEN_I, TIE_RCLOSE_I, TIE_CONN_I,
                INC_BRK_CLOSED_I[1], INC_SRC_OK_I[1], INC_SRCTRIP_I[1], INC_LOCKOUT_I[1],
                INC_BLOCK_I[1], INC_ROPEN_I[1], INC_RCLOSE_I[1], INC_CONN_I[1],
                INC_BRK_CLOSED_I[0], INC_SRC_OK_I[0], INC_SRCTRIP_I[0], INC_LOCKOUT_I[0],
                INC_BLOCK_I[0], INC_ROPEN_I[0], INC_RCLOSE_I[0], INC_CONN_I[0]};

  bts_sync u_sync (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RST_N_I),
    .raw_i   (raw),
    .port    (u_if.syncer)
  );

  bts_evlog u_log (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RST_N_I),
    .port    (u_if.logmem)
  );

  // Per-incomer views of the sampled vector
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      conn[i]      = u_if.lvl[bts_bit(i, IN_CONN)];
      block[i]     = u_if.lvl[bts_bit(i, IN_BLOCK)];
      lock[i]      = u_if.lvl[bts_bit(i, IN_LOCK)];
      srctrip[i]   = u_if.lvl[bts_bit(i, IN_SRCTRIP)];
      src_ok[i]    = u_if.lvl[bts_bit(i, IN_SRCOK)];
      brk[i]       = u_if.lvl[bts_bit(i, IN_BRKCL)];
      rclose_p[i]  = u_if.rise[bts_bit(i, IN_RCLOSE)];
      ropen_p[i]   = u_if.rise[bts_bit(i, IN_ROPEN)];
      lock_p[i]    = u_if.rise[bts_bit(i, IN_LOCK)];
      srctrip_p[i] = u_if.rise[bts_bit(i, IN_SRCTRIP)];
    end
  end

  // Incomer command and timer terms
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      hold[i]      = ~src_ok[i] | (s.dly_cnt[i] != 32'h0);
      uv_trip[i]   = ~src_ok[i] & (s.uv_cnt[i] == 32'h1) & brk[i];
      trip[i]      = ropen_p[i] | s.sw_open[i] | lock[i] | srctrip[i] | uv_trip[i];
      close_cmd[i] = rclose_p[i] | s.sw_close[i];
    end
  end

  assign common_nr = ~u_if.lvl[T_CONN] | u_if.lvl[T_BRKCL] | ~(&conn) | (|block) | ~(&brk);
  assign tie_close = u_if.rise[T_RCLOSE] | s.sw_close[2];
  assign tie_open  = u_if.rise[T_ROPEN] | s.sw_open[2];
  assign snap_now  = {s.nr, s.cmd, u_if.lvl};
  assign setup     = PSEL_I & ~PENABLE_I;
  assign access    = PSEL_I & PENABLE_I;

  always_comb begin
    next_s          = s;
    next_s.sw_close = 3'h0;
    next_s.sw_open  = 3'h0;
    next_s.log_wr   = 1'b0;

    for (int i = 0; i < 2; i++) begin
      if (src_ok[i]) begin
        next_s.uv_cnt[i]  = UV_CYC;
      end else if (s.uv_cnt[i] != 32'h0) begin
        next_s.uv_cnt[i]  = s.uv_cnt[i] - 32'h1;
      end
      if (!src_ok[i]) begin
        next_s.dly_cnt[i] = XFER_CYC;
      end else if (s.dly_cnt[i] != 32'h0) begin
        next_s.dly_cnt[i] = s.dly_cnt[i] - 32'h1;
      end

      if (trip[i]) begin
        next_s.cmd[i]      = 1'b0;
        next_s.cls_pend[i] = 1'b0;
      end else if (s.cls_pend[i] && conn[i] && src_ok[i]) begin
        next_s.cmd[i]      = 1'b1;
        next_s.cls_pend[i] = 1'b0;
      end
      if (close_cmd[i] && !trip[i]) begin
        next_s.cls_pend[i] = 1'b1;
      end

      if (!brk[i]) begin
        next_s.inc_req[i] = 1'b0;
      end
      if (s.auto_en && (lock_p[i] || srctrip_p[i] || uv_trip[i])) begin
        next_s.inc_req[i] = 1'b1;
      end

      // Set before the tie update, which reloads it from inc_req, so a request is never lost
      if (s.inc_req[i]) begin
        next_s.tie_req[i] = 1'b1;
      end
    end

    if (tie_open) begin
      next_s.cmd[2]  = 1'b0;
      next_s.tie_req = s.inc_req;
    end else if (tie_close && u_if.lvl[T_CONN]) begin
      next_s.cmd[2]  = 1'b1;
    end else if (u_if.lvl[T_CONN] && ((s.tie_req[0] && u_if.lvl[T_BUSDEAD]) ||
                                     (s.tie_req[1] && u_if.lvl[T_LINEDEAD]))) begin
      next_s.cmd[2]  = 1'b1;
      next_s.tie_req = s.inc_req;
    end

    for (int i = 0; i < 2; i++) begin
      next_s.nr[i] = common_nr | hold[1-i];
    end

    // incomer and tie relay map
    // Relay 3 takes the new flag so it never lags the not-ready output
    next_s.rly0 = {conn[0] & brk[0] & ~block[0], s.inc_req[0], conn[0] & brk[0] & ~block[0],
                   ~src_ok[0], next_s.nr[0], s.cmd[0], ~s.cmd[0]};
    next_s.rly1 = {conn[1] & brk[1] & ~block[1], s.inc_req[1], conn[1] & brk[1] & ~block[1],
                   ~src_ok[1], next_s.nr[1], s.cmd[1], ~s.cmd[1]};
    next_s.rlyt = {u_if.lvl[T_CONN] & u_if.lvl[T_BRKCL], u_if.lvl[T_CONN],
                   u_if.lvl[T_CONN] & u_if.lvl[T_BRKCL], u_if.lvl[T_CONN], 1'b0, s.cmd[2], ~s.cmd[2]};

    // log each change while room remains
    if (snap_now != s.snap) begin
      next_s.snap = snap_now;
      if (s.wptr < 6'(LOG_DEPTH)) begin
        next_s.log_wr    = 1'b1;
        next_s.log_waddr = s.wptr[LOG_AW-1:0];
        next_s.log_wdata = {s.seq, snap_now};
        next_s.wptr      = s.wptr + 6'h1;
        next_s.seq       = s.seq + 5'h1;
      end
    end

    // Read data is prepared in setup so the access phase needs no wait
    if (setup) begin
      next_s.pslverr = 1'b0;
      unique case (PADDR_I)
        REG_CTRL:     next_s.prdata = {31'h0, s.auto_en};
        REG_CMD:      next_s.prdata = 32'h0;
        REG_STATUS:   next_s.prdata = {23'h0, s.tie_req, s.inc_req, s.nr, s.cmd};
        REG_LOG_CNT:  next_s.prdata = {26'h0, s.wptr};
        REG_LOG_IDX:  next_s.prdata = {27'h0, s.log_idx};
        REG_LOG_DATA: next_s.prdata = u_if.rdata;
        REG_INPUTS:   next_s.prdata = {10'h0, u_if.lvl};
        default: begin
          next_s.prdata  = 32'h0;
          next_s.pslverr = 1'b1;
        end
      endcase
    end

    if (access && PWRITE_I) begin
      unique case (PADDR_I)
        REG_CTRL: begin
          next_s.auto_en = PWDATA_I[0];
          // Clearing restarts numbering; entries beyond the pointer are stale
          if (PWDATA_I[1]) begin
            next_s.wptr = 6'h0;
            next_s.seq  = 5'h0;
          end
        end
        REG_CMD: begin
          next_s.sw_close = PWDATA_I[2:0];
          next_s.sw_open  = PWDATA_I[6:4];
        end
        REG_LOG_IDX: next_s.log_idx = PWDATA_I[LOG_AW-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s          <= '0;
      s.auto_en  <= AUTO_EN_RST;
      s.nr       <= NR_RST;
      s.rly0     <= RLY_INC_RST;
      s.rly1     <= RLY_INC_RST;
      s.rlyt     <= RLY_TIE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign u_if.wr    = s.log_wr;
  assign u_if.waddr = s.log_waddr;
  assign u_if.wdata = s.log_wdata;
  assign u_if.raddr = s.log_idx;

  assign PRDATA_O        = s.prdata;
  assign PREADY_O        = 1'b1;
  assign PSLVERR_O       = s.pslverr & access;
  assign INC0_RELAY_O    = s.rly0;
  assign INC1_RELAY_O    = s.rly1;
  assign TIE_RELAY_O     = s.rlyt;
  assign INC_NOT_READY_O = s.nr;
endmodule // bts_scheme

/* bench/bts_chk.sv */
// Purpose: Port-level checks of the transfer interlock
// Assumes: Ports of bts_scheme only, one clock domain
// Notes:   Latency is two sync stages plus one relay stage, with one state stage more for the command and request relays
module bts_chk #(
  parameter int unsigned XFER_CYC = 20,
  parameter int unsigned UV_CYC   = 40
) (
  // Clock and reset
  input wire logic              CLK_SYS_I,
  input wire logic              RST_N_I,
  // Watched inputs
  input wire logic [1:0]        INC_CONN_I,
  input wire logic [1:0]        INC_BLOCK_I,
  input wire logic [1:0]        INC_LOCKOUT_I,
  input wire logic [1:0]        INC_SRC_OK_I,
  input wire logic [1:0]        INC_BRK_CLOSED_I,
  input wire logic              TIE_CONN_I,
  // Watched relays
  input wire bts_pkg::bts_rly_t INC0_RELAY_O,
  input wire bts_pkg::bts_rly_t INC1_RELAY_O,
  input wire bts_pkg::bts_rly_t TIE_RELAY_O,
  input wire logic [1:0]        INC_NOT_READY_O
);
  timeunit 1ns;
  timeprecision 1ns;
  import bts_pkg::*;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  // Held levels long enough to cross the sampler
  sequence s_tie_in;   TIE_CONN_I[*4]; endsequence
  sequence s_tie_out;  (!TIE_CONN_I)[*5]; endsequence
  sequence s_blocked;  INC_BLOCK_I[0][*5]; endsequence
  sequence s_src_dead; (!INC_SRC_OK_I[0])[*5]; endsequence
  sequence s_locked;   INC_LOCKOUT_I[0][*5]; endsequence
  sequence s_brk_open; (!INC_BRK_CLOSED_I[0])[*6]; endsequence

  a_nr_relay_same: assert property (INC_NOT_READY_O == {INC1_RELAY_O[2], INC0_RELAY_O[2]})
    else $error("not ready flag and relay 3 differ");
  a_tie_conn_on: assert property (s_tie_in |-> TIE_RELAY_O[3] && TIE_RELAY_O[5])
    else $error("tie outputs 4 and 6 not energised");
  a_tie_conn_off: assert property (s_tie_out |-> TIE_RELAY_O[6:3] == 4'h0 && INC_NOT_READY_O == 2'b11)
    else $error("tie racked out but outputs or ready wrong");
  a_close_live_src: assert property ($rose(INC0_RELAY_O[1]) |-> $past(INC_SRC_OK_I[0], 4) && $past(INC_CONN_I[0], 4))
    else $error("incomer closed on dead source");
  a_block_drops: assert property (s_blocked |-> !INC0_RELAY_O[4] && !INC0_RELAY_O[6] && INC_NOT_READY_O == 2'b11)
    else $error("block transfer did not drop outputs");
  a_uv_pickup: assert property (s_src_dead |-> INC0_RELAY_O[3] && INC_NOT_READY_O[1])
    else $error("undervoltage pickup not flagged");
  a_lock_trips: assert property (s_locked |-> INC0_RELAY_O[0] && !INC0_RELAY_O[1])
    else $error("lockout did not trip incomer");
  a_req_released: assert property (s_brk_open |-> !INC0_RELAY_O[5])
    else $error("close request held with breaker open");
  a_tie_close_conn: assert property ($rose(TIE_RELAY_O[1]) |-> $past(TIE_CONN_I, 4))
    else $error("tie closed while racked out");
endmodule // bts_chk

bind bts_scheme bts_chk #(.XFER_CYC(XFER_CYC), .UV_CYC(UV_CYC)) u_bts_chk (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .INC_CONN_I(INC_CONN_I), .INC_BLOCK_I(INC_BLOCK_I),
  .INC_LOCKOUT_I(INC_LOCKOUT_I), .INC_SRC_OK_I(INC_SRC_OK_I), .INC_BRK_CLOSED_I(INC_BRK_CLOSED_I),
  .TIE_CONN_I(TIE_CONN_I), .INC0_RELAY_O(INC0_RELAY_O), .INC1_RELAY_O(INC1_RELAY_O),
  .TIE_RELAY_O(TIE_RELAY_O), .INC_NOT_READY_O(INC_NOT_READY_O));

/* bench/bts_brk_model.sv */
// Purpose: Breaker mechanisms of both incomers and the tie
// Assumes: A held close coil means a closed breaker
// Notes:   LAG is travel time; status is never earlier than the coil
module bts_brk_model #(
  parameter int unsigned LAG = 3
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Close coils and status contacts
  input  wire logic [2:0] coil_i,
  output logic      [2:0] closed_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [LAG-1:0][2:0] pipe;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pipe <= '0;
    end else begin
      pipe <= {pipe[LAG-2:0], coil_i};
    end
  end
  assign closed_o = pipe[LAG-1];
endmodule // bts_brk_model

/* bench/bts_scheme_bench.sv */
// Purpose: Directed bench of the transfer interlock
// Assumes: Shortened transfer and undervoltage delays
// Notes:   Close relays drive the breaker model back into the status inputs
module bts_scheme_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import bts_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, tie_conn = 1'b0;
  logic [1:0]  conn = '0, block = '0, lock = '0, strip = '0, src_ok = '0, dead = '0, nr;
  logic [2:0]  rclose = '0, ropen = '0, brk;
  logic [5:0]  c;
  logic [4:0]  seq0;
  bts_rly_t    rly [3];
  int          errors = 0, checks = 0, cyc = 0, n;

  always #10 clk = ~clk;

  bts_scheme #(.XFER_CYC(20), .UV_CYC(40)) DUT (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .INC_CONN_I(conn), .INC_RCLOSE_I(rclose[1:0]), .INC_ROPEN_I(ropen[1:0]), .INC_BLOCK_I(block),
    .INC_LOCKOUT_I(lock), .INC_SRCTRIP_I(strip), .INC_SRC_OK_I(src_ok), .INC_BRK_CLOSED_I(brk[1:0]),
    .TIE_CONN_I(tie_conn), .TIE_RCLOSE_I(rclose[2]), .TIE_ROPEN_I(ropen[2]), .TIE_BRK_CLOSED_I(brk[2]),
    .TIE_BUS_DEAD_I(dead[0]), .TIE_LINE_DEAD_I(dead[1]), .INC0_RELAY_O(rly[0]), .INC1_RELAY_O(rly[1]),
    .TIE_RELAY_O(rly[2]), .INC_NOT_READY_O(nr));
  bts_brk_model #(.LAG(3)) u_brk (.clk_i(clk), .rst_n_i(rst_n),
    .coil_i({rly[2][1], rly[1][1], rly[0][1]}), .closed_o(brk));

  task automatic go(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic look(input logic [6:0] got, input logic [6:0] v, input logic [1:0] r);
    chk(got, v);
    chk(nr, r);
  endtask
  task automatic hold(input int i, input int b, input logic v);
    n = 0;
    while (rly[i][b] !== v && n < 40) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready is tied high, so this wait ends after one cycle
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int u, input logic cls);
    if (cls) begin
      rclose <= 3'(1 << u);
    end else begin
      ropen <= 3'(1 << u);
    end
    go(4);
    rclose <= '0;
    ropen <= '0;
    go(4);
  endtask
  function automatic logic [21:0] vec();
    return {dead, brk[2], ropen[2], rclose[2], tie_conn, brk[1], src_ok[1], strip[1], lock[1], block[1],
      ropen[1], rclose[1], conn[1], brk[0], src_ok[0], strip[0], lock[0], block[0], ropen[0], rclose[0], conn[0]};
  endfunction
  task automatic complete_run();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, far above the directed run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    go(4);
    chk(nr, 2'b11);
    rst_n <= 1'b1;
    go(10);
    chk({rly[2], rly[1], rly[0]}, 21'h00468d);
    tie_conn <= 1'b1;
    go(10);
    chk(rly[2], 7'h29);
    for (int i = 0; i < 2; i++) begin
      conn <= conn | 2'(1 << i);
      pulse(i, 1'b1);
      go(10);
      chk(rly[i], 7'h0d);
      src_ok <= src_ok | 2'(1 << i);
      go(14);
      chk(rly[i] & 7'h7b, 7'h52);
    end
    go(40);
    chk(nr, 2'b00);
    tie_conn <= 1'b0;
    go(10);
    look(rly[2], 7'h01, 2'b11);
    tie_conn <= 1'b1;
    go(10);
    chk(nr, 2'b00);
    for (int i = 0; i < 2; i++) begin
      conn <= conn & ~2'(1 << i);
      go(10);
      look(rly[i] & 7'h53, 7'h02, 2'b11);
      conn <= 2'b11;
      go(10);
      look(rly[i] & 7'h53, 7'h52, 2'b00);
      block <= 2'(1 << i);
      go(10);
      look(rly[i] & 7'h53, 7'h02, 2'b11);
      block <= '0;
      go(10);
      look(rly[i] & 7'h53, 7'h52, 2'b00);
      pulse(i, 1'b0);
      go(10);
      look(rly[i] & 7'h53, 7'h01, 2'b11);
      pulse(i, 1'b1);
      go(10);
      look(rly[i] & 7'h53, 7'h52, 2'b00);
    end
    pulse(2, 1'b1);
    go(10);
    look(rly[2], 7'h7a, 2'b11);
    pulse(2, 1'b0);
    go(10);
    look(rly[2], 7'h29, 2'b00);
    src_ok <= 2'b10;
    go(6);
    look(rly[0][3], 7'h01, 2'b10);
    src_ok <= 2'b11;
    go(6);
    look(rly[0][3], 7'h00, 2'b10);
    go(25);
    chk(nr, 2'b00);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) begin
        lock <= 2'b01;
      end else begin
        strip <= 2'b10;
      end
      hold(i, 5, 1'b1);
      chk(rly[i][5], 1'b1);
      hold(i, 5, 1'b0);
      chk(brk[i], 1'b0);
      go(10);
      chk(rly[2][1], 1'b0);
      dead <= 2'(1 << i);
      go(10);
      chk(rly[2][1], 1'b1);
      lock <= '0;
      strip <= '0;
      dead <= '0;
      pulse(2, 1'b0);
      pulse(i, 1'b1);
      go(30);
      chk(nr, 2'b00);
    end
    src_ok <= 2'b10;
    dead <= 2'b01;
    go(70);
    chk(rly[0][1:0], 2'b01);
    chk(rly[2][1], 1'b1);
    src_ok <= 2'b11;
    dead <= '0;
    pulse(2, 1'b0);
    pulse(0, 1'b1);
    go(30);
    apb(1'b1, REG_CTRL, 32'h3);
    block <= 2'b01;
    go(10);
    apb(1'b0, REG_LOG_CNT, '0);
    c = rd[5:0];
    apb(1'b1, REG_LOG_IDX, 32'(c - 6'd2));
    go(2);
    apb(1'b0, REG_LOG_DATA, '0);
    seq0 = rd[31:27];
    apb(1'b1, REG_LOG_IDX, 32'(c - 6'd1));
    go(2);
    apb(1'b0, REG_LOG_DATA, '0);
    chk(rd[31:27], seq0 + 5'd1);
    chk(rd[26:0], {nr, 3'h3, vec()});
    apb(1'b0, 8'h1c, '0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    apb(1'b0, REG_INPUTS, '0);
    chk(rd, {10'h0, vec()});
    apb(1'b0, REG_STATUS, '0);
    chk(rd, 32'h1b);
    apb(1'b1, REG_CMD, 32'h10);
    go(12);
    chk(rly[0][1:0], 2'b01);
    apb(1'b1, REG_CMD, 32'h1);
    go(14);
    chk(rly[0][1:0], 2'b10);
    complete_run();
  end
endmodule // bts_scheme_bench
